// ===== logic/dac_ctrl_pkg.sv
package dac_ctrl_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [4:0] ADDR_SYSTEM_CONTROL = 5'h00;
    localparam logic [4:0] ADDR_FILTER_MUTE_CONTROL = 5'h01;
    localparam logic [4:0] ADDR_ZERO_FLAG_POLARITY = 5'h02;
    localparam logic [4:0] ADDR_LEFT_ATTENUATION = 5'h03;
    localparam logic [4:0] ADDR_RIGHT_ATTENUATION = 5'h04;
    localparam int NUM_REGS = 5;

    localparam logic [7:0] RST_SYSTEM_CONTROL = 8'h8B;
    localparam logic [7:0] RST_FILTER_MUTE_CONTROL = 8'h02;
    localparam logic [7:0] RST_ZERO_FLAG_POLARITY = 8'h00;
    localparam logic [7:0] RST_ATTENUATION = 8'hFF;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_TIMING_RESET = 0;
    localparam int BIT_POWER_ENABLE = 1;
    localparam int BIT_SOFT_QUIET = 0;
    localparam int BIT_SPEED_LO = 3;
    localparam int BIT_SPEED_HI = 4;
    localparam int BIT_SILENCE_JOINT = 6;
    localparam int BIT_SILENCE_ENABLE = 7;
    localparam int BIT_SILENCE_INVERT = 2;

    // ************************************************************
    // Frame format
    // ************************************************************
    localparam int FRAME_BITS = 16;
    localparam logic [1:0] CHIP_ADDR = 2'h1;
    localparam logic RW_WRITE = 1'b1;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int SYS_CLK_MHZ = 200;
    localparam int STEP_FRAMES_NORMAL = 4;
    localparam int STEP_FRAMES_DOUBLE = 8;
    localparam int STEP_FRAMES_QUAD = 16;
    localparam int SILENCE_FRAMES = 8192;
    localparam int RESET_ENTER_FRAMES = 3;
    localparam int RESET_LEAVE_FRAMES = 2;
    localparam int MCLK_TIMEOUT_NS = 1000;
    localparam int MCLK_TIMEOUT_CYCLES = MCLK_TIMEOUT_NS * SYS_CLK_MHZ / 1000;
    localparam int CTRL_CLK_MAX_KHZ = 5000;
    localparam int CTRL_HALF_CYCLES = (SYS_CLK_MHZ * 1000 + 2 * CTRL_CLK_MAX_KHZ - 1) / (2 * CTRL_CLK_MAX_KHZ);

endpackage

// ===== logic/dac_ctrl_if.sv
`timescale 1ns/1ps
interface dac_ctrl_if;
    logic ctrl_select_n;
    logic ctrl_serial_clock;
    logic ctrl_serial_in;
    logic power_down_pin_n;

    modport device (
        input ctrl_select_n,
        input ctrl_serial_clock,
        input ctrl_serial_in,
        input power_down_pin_n
    );

    modport host (
        output ctrl_select_n,
        output ctrl_serial_clock,
        output ctrl_serial_in,
        output power_down_pin_n
    );
endinterface

// ===== logic/dac_ctrl_device.sv
// Operation
// - Soft quiet set ramps level down to mute.
// - Soft quiet cleared ramps back to programmed level.
// - Early release reverses ramp at same rate.
// - Step time 4, 8 or 16 frames.
// - Silence flag after 8192 zero frames.
// - Host pulses power-down low after power-up.
// - Stay powered down until clocks present.
// - Power-down pin low floats outputs, flags low.
// - Clocks may stop in power-down or reset.
// - Timing reset bit low: mid-rail, flags high.
// - Internal reset enters 3, leaves 2 frames; the code switches on the 4th and 3rd frame edge.
// - Frame: addr 01, write 1, 5+8 bits.
// - Sample data on control clock rising edge.
// - Commit frame on select rising edge.
// - Host control clock at most 5MHz.
// - Write-only port, no chip address select.
// - Ignore writes in power-down or no master clock.
// - Power-down pin restores register defaults.
// - Host never writes addresses 05H to 1FH.
// - Writes accepted while power or timing bit low.
// - Register 00H bit 0 is timing reset.
// - Host resets after clock or speed change.
// - Power enable bit low powers converter down.
`timescale 1ns/1ps
module dac_ctrl_device
    import dac_ctrl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    dac_ctrl_if.device ctrl,
    input wire logic master_clock,
    input wire logic frame_clock,
    input wire logic left_zero_data,
    input wire logic right_zero_data,
    output logic [1:0] left_right_silence_flags,
    output logic [7:0] left_volume_level,
    output logic [7:0] right_volume_level,
    output logic outputs_float,
    output logic outputs_mid_rail,
    output logic converter_active,
    output logic [1:0] speed_sel,
    output logic [7:0] system_control,
    output logic [7:0] filter_mute_control,
    output logic [7:0] zero_flag_polarity
);
    import dac_ctrl_pkg::*;

    typedef enum logic [1:0] {
        ST_DOWN = 2'b00,
        ST_WAIT_FRAME = 2'b01,
        ST_RUN = 2'b10
    } run_state_e;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic [5:0] sync3_reg;
    always_ff @(posedge sys_clk) begin
        sync1_reg <= {ctrl.ctrl_select_n, ctrl.ctrl_serial_clock, ctrl.ctrl_serial_in,
                      ctrl.power_down_pin_n, master_clock, frame_clock};
        sync2_reg <= sync1_reg;
        sync3_reg <= sync2_reg;
    end
    wire sel_n_s = sync2_reg[5];
    wire sclk_s = sync2_reg[4];
    wire sdin_s = sync2_reg[3];
    wire pdn_s = sync2_reg[2];
    wire mclk_s = sync2_reg[1];
    wire frame_s = sync2_reg[0];
    wire sclk_rise = sclk_s & ~sync3_reg[4];
    wire sel_rise = sel_n_s & ~sync3_reg[5];
    wire frame_rise = frame_s & ~sync3_reg[0];
    wire mclk_edge = mclk_s ^ sync3_reg[1];
    wire dev_rst = ~nrst | ~pdn_s;

    // ************************************************************
    // Master clock presence
    // ************************************************************
    logic [7:0] mclk_timer_reg;
    always_ff @(posedge sys_clk) begin
        if (dev_rst) begin
            mclk_timer_reg <= 8'(MCLK_TIMEOUT_CYCLES);
        end else if (mclk_edge) begin
            mclk_timer_reg <= 8'h00;
        end else if (mclk_timer_reg != 8'(MCLK_TIMEOUT_CYCLES)) begin
            mclk_timer_reg <= mclk_timer_reg + 8'h01;
        end
    end
    wire mclk_present = (mclk_timer_reg != 8'(MCLK_TIMEOUT_CYCLES));

    // ************************************************************
    // Serial control port
    // ************************************************************
    logic [15:0] shift_reg;
    logic [4:0] count_reg;
    logic [7:0] regs_reg [NUM_REGS];
    logic [7:0] reset_vals [NUM_REGS];
    assign reset_vals[0] = RST_SYSTEM_CONTROL;
    assign reset_vals[1] = RST_FILTER_MUTE_CONTROL;
    assign reset_vals[2] = RST_ZERO_FLAG_POLARITY;
    assign reset_vals[3] = RST_ATTENUATION;
    assign reset_vals[4] = RST_ATTENUATION;

    wire frame_full = (count_reg == 5'(FRAME_BITS));
    wire addr_ok = (shift_reg[15:14] == CHIP_ADDR) & (shift_reg[13] == RW_WRITE);
    wire write_ok = sel_rise & frame_full & addr_ok & mclk_present;

    always_ff @(posedge sys_clk) begin
        if (dev_rst | sel_n_s) begin
            count_reg <= 5'h00;
        end else if (sclk_rise & ~frame_full) begin
            shift_reg <= {shift_reg[14:0], sdin_s};
            count_reg <= count_reg + 5'h01;
        end
    end

    // Writes never gated by control bits.
    generate
        for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
            always_ff @(posedge sys_clk) begin
                if (dev_rst) begin
                    regs_reg[i] <= reset_vals[i];
                end else if (write_ok & (shift_reg[12:8] == 5'(i))) begin
                    regs_reg[i] <= shift_reg[7:0];
                end
            end
        end
    endgenerate

    assign system_control = regs_reg[0];
    assign filter_mute_control = regs_reg[1];
    assign zero_flag_polarity = regs_reg[2];
    wire timing_reset_bit_n = regs_reg[0][BIT_TIMING_RESET];
    wire power_enable_bit = regs_reg[0][BIT_POWER_ENABLE];
    wire soft_quiet_enable = regs_reg[1][BIT_SOFT_QUIET];
    assign speed_sel = regs_reg[1][BIT_SPEED_HI:BIT_SPEED_LO];
    wire silence_detect_enable = regs_reg[1][BIT_SILENCE_ENABLE];
    wire silence_detect_joint = regs_reg[1][BIT_SILENCE_JOINT];
    wire silence_flag_invert = regs_reg[2][BIT_SILENCE_INVERT];

    // ************************************************************
    // Run state and internal timing reset
    // ************************************************************
    run_state_e state_reg;
    run_state_e state_next;
    logic int_reset_n_reg;
    logic [1:0] rst_cnt_reg;
    // Wait for clocks, start on frame edge.
    // Missing clocks hold ST_DOWN, and drop ST_WAIT_FRAME or ST_RUN back to ST_DOWN.
    always_comb begin
        case (state_reg)
            ST_DOWN: state_next = mclk_present ? ST_WAIT_FRAME : ST_DOWN;
            ST_WAIT_FRAME: state_next = !mclk_present ? ST_DOWN : (frame_rise ? ST_RUN : ST_WAIT_FRAME);
            ST_RUN: state_next = mclk_present ? ST_RUN : ST_DOWN;
            default: state_next = ST_DOWN;
        endcase
    end
    wire running = (state_reg == ST_RUN);
    wire rst_pending = (timing_reset_bit_n != int_reset_n_reg);
    wire [1:0] rst_target = timing_reset_bit_n ? 2'(RESET_LEAVE_FRAMES) : 2'(RESET_ENTER_FRAMES);

    always_ff @(posedge sys_clk) begin
        if (dev_rst) begin
            state_reg <= ST_DOWN;
            int_reset_n_reg <= 1'b1;
            rst_cnt_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            if (!rst_pending) begin
                rst_cnt_reg <= 2'h0;
            end else if (frame_rise | ~running) begin
                if (rst_cnt_reg == rst_target || !running) begin
                    int_reset_n_reg <= timing_reset_bit_n;
                    rst_cnt_reg <= 2'h0;
                end else begin
                    rst_cnt_reg <= rst_cnt_reg + 2'h1;
                end
            end
        end
    end
    wire timing_live = running & int_reset_n_reg;
    assign converter_active = timing_live & power_enable_bit;
    assign outputs_float = ~pdn_s;
    assign outputs_mid_rail = pdn_s & ~int_reset_n_reg;

    // ************************************************************
    // Per-channel volume ramp and silence counters
    // ************************************************************
    logic [4:0] step_frames;
    assign step_frames = (speed_sel == 2'h2) ? 5'(STEP_FRAMES_QUAD) :
                         (speed_sel == 2'h1) ? 5'(STEP_FRAMES_DOUBLE) : 5'(STEP_FRAMES_NORMAL);
    logic [4:0] step_cnt_reg;
    wire step_tick = timing_live & frame_rise & (step_cnt_reg == step_frames - 5'h01);
    always_ff @(posedge sys_clk) begin
        if (dev_rst | ~timing_live) begin
            step_cnt_reg <= 5'h00;
        end else if (frame_rise) begin
            step_cnt_reg <= step_tick ? 5'h00 : step_cnt_reg + 5'h01;
        end
    end

    logic [7:0] level_reg [2];
    logic [13:0] zero_cnt_reg [2];
    logic [1:0] zero_hit;
    wire [1:0] zero_in = {right_zero_data, left_zero_data};
    generate
        for (genvar c = 0; c < 2; c++) begin : g_ch
            wire [7:0] volume_code = regs_reg[3 + c];
            // Target is mute or programmed level.
            wire [7:0] target = soft_quiet_enable ? 8'h00 : volume_code;
            always_ff @(posedge sys_clk) begin
                if (dev_rst) begin
                    level_reg[c] <= RST_ATTENUATION;
                end else if (step_tick & (level_reg[c] > target)) begin
                    level_reg[c] <= level_reg[c] - 8'h01;
                end else if (step_tick & (level_reg[c] < target)) begin
                    level_reg[c] <= level_reg[c] + 8'h01;
                end
            end
            always_ff @(posedge sys_clk) begin
                if (dev_rst | ~timing_live | ~zero_in[c]) begin
                    zero_cnt_reg[c] <= 14'h0000;
                end else if (frame_rise & ~zero_hit[c]) begin
                    zero_cnt_reg[c] <= zero_cnt_reg[c] + 14'h0001;
                end
            end
            assign zero_hit[c] = zero_in[c] & (zero_cnt_reg[c] == 14'(SILENCE_FRAMES));
        end
    endgenerate
    assign left_volume_level = level_reg[0];
    assign right_volume_level = level_reg[1];

    wire [1:0] detect = silence_detect_joint ? {2{&zero_hit}} : zero_hit;
    logic [1:0] flags_next;
    // Flag forcing by power and reset state.
    always_comb begin
        if (!pdn_s) begin
            flags_next = 2'h0;
        end else if (!int_reset_n_reg) begin
            flags_next = 2'h3;
        end else if (!silence_detect_enable) begin
            flags_next = 2'h0;
        end else begin
            flags_next = detect ^ {2{silence_flag_invert}};
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            left_right_silence_flags <= 2'h0;
        end else begin
            left_right_silence_flags <= flags_next;
        end
    end
endmodule

// ===== logic/dac_ctrl_host.sv
`timescale 1ns/1ps
module dac_ctrl_host
    import dac_ctrl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    dac_ctrl_if.host ctrl,
    input wire logic power_down_req,
    input wire logic wr_valid,
    input wire logic [4:0] wr_addr,
    input wire logic [7:0] wr_data,
    output logic wr_ready
);
    import dac_ctrl_pkg::*;

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_LOW = 2'b01,
        H_HIGH = 2'b10,
        H_END = 2'b11
    } host_state_e;

    host_state_e state_reg;
    logic [15:0] frame_reg;
    logic [4:0] bits_reg;
    logic [7:0] half_reg;
    logic sel_n_reg;
    logic sclk_reg;
    logic sdo_reg;
    logic pdn_reg;

    wire half_done = (half_reg == 8'(CTRL_HALF_CYCLES - 1));
    wire low_done = (half_reg == 8'(CTRL_HALF_CYCLES));
    wire addr_legal = (wr_addr < 5'(NUM_REGS));
    assign wr_ready = (state_reg == H_IDLE) & pdn_reg;

    // Power-down pin low during reset and on request.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pdn_reg <= 1'b0;
        end else begin
            pdn_reg <= ~power_down_req;
        end
    end

    // Frame out, data changes on falling edge.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_reg <= H_IDLE;
            frame_reg <= 16'h0000;
            bits_reg <= 5'h00;
            half_reg <= 8'h00;
            sel_n_reg <= 1'b1;
            sclk_reg <= 1'b1;
            sdo_reg <= 1'b0;
        end else begin
            case (state_reg)
                H_IDLE: begin
                    half_reg <= 8'h00;
                    if (wr_valid & wr_ready & addr_legal) begin
                        frame_reg <= {CHIP_ADDR, RW_WRITE, wr_addr, wr_data};
                        bits_reg <= 5'h00;
                        sel_n_reg <= 1'b0;
                        state_reg <= H_LOW;
                    end
                end
                H_LOW: begin
                    half_reg <= low_done ? 8'h00 : half_reg + 8'h01;
                    if (half_reg == 8'h00) begin
                        sclk_reg <= 1'b0;
                        sdo_reg <= frame_reg[15];
                        frame_reg <= {frame_reg[14:0], 1'b0};
                    end
                    if (low_done) begin
                        sclk_reg <= 1'b1;
                        bits_reg <= bits_reg + 5'h01;
                        state_reg <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    half_reg <= half_done ? 8'h00 : half_reg + 8'h01;
                    if (half_done) begin
                        state_reg <= (bits_reg == 5'(FRAME_BITS)) ? H_END : H_LOW;
                    end
                end
                H_END: begin
                    half_reg <= half_done ? 8'h00 : half_reg + 8'h01;
                    if (half_done) begin
                        sel_n_reg <= 1'b1;
                        state_reg <= H_IDLE;
                    end
                end
                default: state_reg <= H_IDLE;
            endcase
        end
    end

    assign ctrl.ctrl_select_n = sel_n_reg;
    assign ctrl.ctrl_serial_clock = sclk_reg;
    assign ctrl.ctrl_serial_in = sdo_reg;
    assign ctrl.power_down_pin_n = pdn_reg;
endmodule

// ===== tb/dac_ctrl_chk.sv
`timescale 1ns/1ps
module dac_ctrl_chk
    import dac_ctrl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ctrl_select_n,
    input wire logic ctrl_serial_clock,
    input wire logic ctrl_serial_in,
    input wire logic power_down_pin_n
);
    logic sclk_d;
    logic [7:0] stable_reg;
    logic [4:0] bits_reg;
    logic [15:0] frame_reg;
    wire sclk_edge = ctrl_serial_clock != sclk_d;
    wire sclk_rise = ctrl_serial_clock && !sclk_d;
    // ********
    // Link checks
    // ********
    always_ff @(posedge sys_clk) begin
        sclk_d <= ctrl_serial_clock;
        if (!nrst || sclk_edge) begin
            stable_reg <= 8'h00;
        end else if (stable_reg != 8'hFF) begin
            stable_reg <= stable_reg + 8'h01;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!nrst || ctrl_select_n) begin
            bits_reg <= 5'h00;
        end else if (sclk_rise) begin
            bits_reg <= bits_reg + 5'h01;
            frame_reg <= {frame_reg[14:0], ctrl_serial_in};
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    idle_clock_a: assert property (ctrl_select_n |-> ctrl_serial_clock)
        else $error("clock not idle");
    data_fall_a: assert property (!ctrl_select_n && $changed(ctrl_serial_in) |-> !ctrl_serial_clock)
        else $error("data moved with clock high");
    clock_rate_a: assert property (!ctrl_select_n && sclk_edge |-> stable_reg >= 8'(CTRL_HALF_CYCLES - 1))
        else $error("serial clock too fast");
    frame_bits_a: assert property ($rose(ctrl_select_n) |-> bits_reg == 5'h10)
        else $error("frame length wrong");
    chip_addr_a: assert property ($rose(ctrl_select_n) |-> frame_reg[15:13] == {CHIP_ADDR, RW_WRITE})
        else $error("chip address or write bit wrong");
    addr_range_a: assert property ($rose(ctrl_select_n) |-> frame_reg[12:8] < 5'(NUM_REGS))
        else $error("register address out of range");
    select_hold_a: assert property ($fell(ctrl_select_n) |=> !ctrl_select_n [*8])
        else $error("select released early");
    pin_quiet_a: assert property (!power_down_pin_n |-> ctrl_select_n)
        else $error("frame sent in power-down");
endmodule

// ===== tb/test_dac_control_port_and_reset.sv
`timescale 1ns/1ps
module test_dac_control_port_and_reset;
    import dac_ctrl_pkg::*;
    logic sys_clk = 1'b0, nrst = 1'b0, master_clock = 1'b0, frame_clock = 1'b0, lz = 1'b0, rz = 1'b0;
    logic pd_req = 1'b0, wr_valid = 1'b0, mclk_run = 1'b0, wr_ready, flt, mid, act;
    logic [4:0] wr_addr = 5'h00;
    logic [7:0] wr_data = 8'h00, lvl_l, lvl_r, sc, fmc, zfp;
    logic [1:0] flags, speed;
    int err_total = 0, compares = 0, cyc = 0;
    dac_ctrl_if i_dac_ctrl_if ();
    dac_ctrl_host i_dac_ctrl_host (.sys_clk(sys_clk), .nrst(nrst), .ctrl(i_dac_ctrl_if.host),
        .power_down_req(pd_req), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .wr_ready(wr_ready));
    dac_ctrl_device i_dac_ctrl_device (.sys_clk(sys_clk), .nrst(nrst), .ctrl(i_dac_ctrl_if.device),
        .master_clock(master_clock), .frame_clock(frame_clock), .left_zero_data(lz), .right_zero_data(rz),
        .left_right_silence_flags(flags), .left_volume_level(lvl_l), .right_volume_level(lvl_r),
        .outputs_float(flt), .outputs_mid_rail(mid), .converter_active(act), .speed_sel(speed),
        .system_control(sc), .filter_mute_control(fmc), .zero_flag_polarity(zfp));
    dac_ctrl_chk i_dac_ctrl_chk (.sys_clk(sys_clk), .nrst(nrst), .ctrl_select_n(i_dac_ctrl_if.ctrl_select_n),
        .ctrl_serial_clock(i_dac_ctrl_if.ctrl_serial_clock), .ctrl_serial_in(i_dac_ctrl_if.ctrl_serial_in),
        .power_down_pin_n(i_dac_ctrl_if.power_down_pin_n));
    // ********
    // Clocks and helpers
    // ********
    initial forever #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        frame_clock <= cyc[2];
        master_clock <= mclk_run ? ~master_clock : master_clock;
        if (cyc == 98000) begin
            err_total++;
            complete_run();
        end
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_frames(input int n);
        repeat (n) @(posedge frame_clock);
        @(negedge sys_clk);
    endtask
    task automatic wait_ready;
        int n;
        n = 0;
        while (wr_ready !== 1'b1 && n < 3000) begin
            @(posedge sys_clk);
            n++;
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        wait_ready();
        wr_addr <= a;
        wr_data <= d;
        wr_valid <= 1'b1;
        @(posedge sys_clk);
        wr_valid <= 1'b0;
        repeat (2) @(posedge sys_clk);
        wait_ready();
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic step_len(output int n, output logic [7:0] v);
        for (int i = 0; i < 2; i++) begin
            v = lvl_l;
            n = 0;
            while (lvl_l === v && n < 40) begin
                wait_frames(1);
                n++;
            end
        end
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_start;
        wait_frames(3);
        check("active", 8'h00, 8'(act));
        wait_frames(27);
        check("active", 8'h00, 8'(act));
        @(posedge sys_clk);
        mclk_run <= 1'b1;
        wait_frames(4);
        check("active", 8'h01, 8'(act));
        check("sys", RST_SYSTEM_CONTROL, sc);
        check("filt", RST_FILTER_MUTE_CONTROL, fmc);
        $display("start done");
    endtask
    task automatic t_cfg;
        wr(ADDR_SYSTEM_CONTROL, 8'h89);
        check("sys", 8'h89, sc);
        check("active", 8'h00, 8'(act));
        wr(ADDR_SYSTEM_CONTROL, 8'h8B);
        wr(ADDR_ZERO_FLAG_POLARITY, 8'h04);
        check("active", 8'h01, 8'(act));
        check("pol", 8'h04, zfp);
        @(posedge sys_clk);
        wr_addr <= 5'h05;
        wr_valid <= 1'b1;
        wait_frames(5);
        check("ready", 8'h01, 8'(wr_ready));
        @(posedge sys_clk);
        wr_valid <= 1'b0;
        mclk_run <= 1'b0;
        repeat (300) @(posedge sys_clk);
        wr(ADDR_ZERO_FLAG_POLARITY, 8'h00);
        check("pol", 8'h04, zfp);
        @(posedge sys_clk);
        mclk_run <= 1'b1;
        wr(ADDR_ZERO_FLAG_POLARITY, 8'h00);
        check("pol", 8'h00, zfp);
        $display("config done");
    endtask
    task automatic t_rst;
        wr(ADDR_SYSTEM_CONTROL, 8'h8A);
        wait_frames(3);
        check("mid", 8'h00, 8'(mid));
        wait_frames(2);
        check("mid", 8'h01, 8'(mid));
        check("flags", 8'h03, 8'(flags));
        check("sys", 8'h8A, sc);
        wr(ADDR_SYSTEM_CONTROL, 8'h8B);
        wait_frames(2);
        check("mid", 8'h01, 8'(mid));
        wait_frames(2);
        check("mid", 8'h00, 8'(mid));
        check("flags", 8'h00, 8'(flags));
        $display("timing reset done");
    endtask
    task automatic t_ramp;
        int n, step[3];
        logic [7:0] v;
        step = '{STEP_FRAMES_NORMAL, STEP_FRAMES_DOUBLE, STEP_FRAMES_QUAD};
        wr(ADDR_FILTER_MUTE_CONTROL, 8'h01);
        wait_frames(1030);
        check("left", 8'h00, lvl_l);
        check("right", 8'h00, lvl_r);
        for (int s = 0; s < 3; s++) begin
            wr(ADDR_FILTER_MUTE_CONTROL, {3'h0, 2'(s), 3'h0});
            check("speed", 8'(s), 8'(speed));
            step_len(n, v);
            check("up step", 8'(step[s]), 8'(n));
            check("up level", v + 8'h01, lvl_l);
            wait_frames(8 * step[s]);
            wr(ADDR_FILTER_MUTE_CONTROL, {3'h0, 2'(s), 3'h1});
            step_len(n, v);
            check("down step", 8'(step[s]), 8'(n));
            check("down level", v - 8'h01, lvl_l);
        end
        $display("ramp done");
    endtask
    task automatic t_silence;
        wr(ADDR_FILTER_MUTE_CONTROL, 8'h80);
        @(posedge sys_clk);
        lz <= 1'b1;
        rz <= 1'b1;
        wait_frames(8188);
        check("flags", 8'h00, 8'(flags));
        wait_frames(6);
        check("flags", 8'h03, 8'(flags));
        @(posedge sys_clk);
        lz <= 1'b0;
        repeat (3) @(negedge sys_clk);
        check("flags", 8'h02, 8'(flags));
        wr(ADDR_ZERO_FLAG_POLARITY, 8'h04);
        check("flags", 8'h01, 8'(flags));
        $display("silence done");
    endtask
    task automatic t_pin;
        @(posedge sys_clk);
        pd_req <= 1'b1;
        wait_frames(2);
        check("float", 8'h01, 8'(flt));
        check("flags", 8'h00, 8'(flags));
        check("ready", 8'h00, 8'(wr_ready));
        check("filt", RST_FILTER_MUTE_CONTROL, fmc);
        check("pol", RST_ZERO_FLAG_POLARITY, zfp);
        @(posedge sys_clk);
        pd_req <= 1'b0;
        wait_frames(4);
        check("float", 8'h00, 8'(flt));
        $display("power-down done");
    endtask
    task automatic complete_run;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        t_start();
        t_cfg();
        t_rst();
        t_ramp();
        t_silence();
        t_pin();
        complete_run();
    end
endmodule
